// ==== pio_ports_cg.sv ====
// Parallel I/O ports C, D, E, F and G with direction, open-drain and
// mode-dependent alternate functions. Assumes SPI, SCI, chip-select
// and mode inputs come from logic on CLK; pin inputs are asynchronous.
//
// Notes on behaviour
// - Port C direction bit set means output
// - Port D lines 5..0 GPIO or serial
// - Reset clears port D direction bits
// - Port D open drain: one floats pin
// - Port D direction upper two bits zero
// - Line 5: slave ignores bit, master selects
// - SPI inputs forced; SPI outputs need direction
// - Port E eight input-only lines
// - Port F outputs or low address
// - Port G resets input; expanded gives prog select
// - Port G 7..4 chip selects, all bidirectional
// - Port G open drain in any mode
// - Port G direction bits reset zero
// - Options: G od, C od, quad clock
// - Options bits 4..0 read zero
// - Port C open drain single-chip only
// - Expanded port C is data bus
`timescale 1ns/10ps
`include "pio_cg_params.svh"
module pio_ports_cg (
  // Clock, reset, enable
  input  wire logic                   CLK,
  input  wire logic                   RESETN,
  input  wire logic                   CE,
  // APB register bus
  input  wire logic                   PSEL,
  input  wire logic                   PENABLE,
  input  wire logic                   PWRITE,
  input  wire logic [15:0]            PADDR,
  input  wire logic [31:0]            PWDATA,
  output      logic                   PREADY,
  output      logic [31:0]            PRDATA,
  output      logic                   PSLVERR,
  // Operating mode: expanded or test when high
  input  wire logic                   MODE_EXPANDED,
  // Serial units
  input  wire logic                   SPI_ENABLE,
  input  wire pio_cg_pkg::spi_role_e  SPI_ROLE,
  input  wire logic [2:0]             SPI_WANTS_OUT,
  input  wire logic [2:0]             SPI_DOUT,
  input  wire logic                   PORT_D_OPEN_DRAIN,
  input  wire logic                   SCI_TX_EN,
  input  wire logic                   SCI_TXD,
  input  wire logic                   SCI_RX_EN,
  output      logic [2:0]             SPI_DIN,
  output      logic                   SPI_LINE5_IN,
  output      logic                   SCI_RXD,
  // Expanded bus and chip selects
  input  wire logic                   EXT_BUS_WRITE,
  input  wire logic [7:0]             EXT_DATA_OUT,
  input  wire logic [7:0]             EXT_ADDR_LO,
  input  wire logic [3:0]             CS_ENABLE,
  input  wire logic [3:0]             CS_LEVEL,
  output      logic [7:0]             EXT_DATA_IN,
  output      logic                   QUAD_CLOCK_OUT_EN,
  // Pins
  input  wire logic [7:0]             PC_IN,
  output      logic [7:0]             PC_OUT,
  output      logic [7:0]             PC_OE,
  input  wire logic [5:0]             PD_IN,
  output      logic [5:0]             PD_OUT,
  output      logic [5:0]             PD_OE,
  input  wire logic [7:0]             PE_IN,
  output      logic [7:0]             PF_OUT,
  input  wire logic [7:0]             PG_IN,
  output      logic [7:0]             PG_OUT,
  output      logic [7:0]             PG_OE
);
  import pio_cg_pkg::*;

  // --------------------------------------------------------------------
  // Bus slave and pin synchronisers
  // --------------------------------------------------------------------
  pio_regbus_if rb ();

  pio_apb_slave u_apb (
    .clk     (CLK),
    .resetn  (RESETN),
    .ce      (CE),
    .psel    (PSEL),
    .penable (PENABLE),
    .pwrite  (PWRITE),
    .paddr   (PADDR),
    .pwdata  (PWDATA),
    .pready  (PREADY),
    .prdata  (PRDATA),
    .pslverr (PSLVERR),
    .bus     (rb.slave)
  );

  byte_t      pc_s;
  byte_t      pe_s;
  byte_t      pg_s;
  logic [5:0] pd_s6;
  byte_t      pd_s;

  pio_sync #(.W(8)) u_sync_c (.clk(CLK), .resetn(RESETN), .ce(CE), .d(PC_IN), .q(pc_s));
  pio_sync #(.W(6)) u_sync_d (.clk(CLK), .resetn(RESETN), .ce(CE), .d(PD_IN), .q(pd_s6));
  pio_sync #(.W(8)) u_sync_e (.clk(CLK), .resetn(RESETN), .ce(CE), .d(PE_IN), .q(pe_s));
  pio_sync #(.W(8)) u_sync_g (.clk(CLK), .resetn(RESETN), .ce(CE), .d(PG_IN), .q(pg_s));

  assign pd_s = {2'b00, pd_s6};

  // --------------------------------------------------------------------
  // Register decode
  // --------------------------------------------------------------------
  logic hit_gd;
  logic hit_gr;
  logic hit_fd;
  logic hit_cd;
  logic hit_cr;
  logic hit_dd;
  logic hit_dr;
  logic hit_e;
  logic hit_o;

  assign hit_gd = rb.idx == `IDX_PORT_G_DATA;
  assign hit_gr = rb.idx == `IDX_PORT_G_DIR;
  // Data bus and address modes take these out of the map
  assign hit_fd = (rb.idx == `IDX_PORT_F_DATA) & ~MODE_EXPANDED;
  assign hit_cd = (rb.idx == `IDX_PORT_C_DATA) & ~MODE_EXPANDED;
  assign hit_cr = rb.idx == `IDX_PORT_C_DIR;
  assign hit_dd = rb.idx == `IDX_PORT_D_DATA;
  assign hit_dr = rb.idx == `IDX_PORT_D_DIR;
  assign hit_e  = rb.idx == `IDX_PORT_E_IN;
  assign hit_o  = rb.idx == `IDX_SYSOPT;

  assign rb.miss = ~(hit_gd | hit_gr | hit_fd | hit_cd | hit_cr
                   | hit_dd | hit_dr | hit_e | hit_o);

  // --------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------
  byte_t pc_lat_q;
  byte_t pc_dir_q;
  byte_t pd_lat_q;
  byte_t pd_dir_q;
  byte_t pf_lat_q;
  byte_t pg_lat_q;
  byte_t pg_dir_q;
  byte_t sysopt_q;

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      pc_lat_q <= `RST_DATA;
      pc_dir_q <= `RST_DIR;
      pd_lat_q <= `RST_DATA;
      pd_dir_q <= `RST_DIR;
      pf_lat_q <= `RST_DATA;
      pg_lat_q <= `RST_DATA;
      pg_dir_q <= `RST_DIR;
      sysopt_q <= `RST_SYSOPT;
    end else if (CE && rb.wr_stb) begin
      if (hit_cd) pc_lat_q <= rb.wdata;
      if (hit_cr) pc_dir_q <= rb.wdata;
      if (hit_dd) pd_lat_q <= rb.wdata & `PD_IMPL_MASK;
      if (hit_dr) pd_dir_q <= rb.wdata & `PD_IMPL_MASK;
      if (hit_fd) pf_lat_q <= rb.wdata;
      if (hit_gd) pg_lat_q <= rb.wdata;
      if (hit_gr) pg_dir_q <= rb.wdata;
      if (hit_o)  sysopt_q <= rb.wdata & `SYSOPT_IMPL_MASK;
    end
  end

  logic g_od;
  logic c_od;

  assign g_od              = sysopt_q[`SYSOPT_G_OD_BIT];
  assign c_od              = sysopt_q[`SYSOPT_C_OD_BIT] & ~MODE_EXPANDED;
  assign QUAD_CLOCK_OUT_EN = sysopt_q[`SYSOPT_QCLK_BIT];

  // --------------------------------------------------------------------
  // Port C: GPIO or data bus
  // --------------------------------------------------------------------
  assign PC_OUT      = MODE_EXPANDED ? EXT_DATA_OUT : pc_lat_q;
  assign PC_OE       = MODE_EXPANDED ? {8{EXT_BUS_WRITE}}
                                     : drive_en(pc_dir_q, pc_lat_q, c_od);
  assign EXT_DATA_IN = pc_s;

  // --------------------------------------------------------------------
  // Port D: GPIO shared with SCI (lines 1..0) and SPI (lines 5..2)
  // --------------------------------------------------------------------
  logic       spi_master;
  logic [5:0] pd_dir;
  byte_t      pd_val;

  assign spi_master = SPI_ROLE == SPI_ROLE_MASTER;

  // Receive line is forced to input, transmit line to output
  assign pd_dir[`PD_SCI_RX_LINE] = pd_dir_q[`PD_SCI_RX_LINE] & ~SCI_RX_EN;
  assign pd_dir[`PD_SCI_TX_LINE] = pd_dir_q[`PD_SCI_TX_LINE] | SCI_TX_EN;
  assign pd_dir[4:2] = SPI_ENABLE ? (pd_dir_q[4:2] & SPI_WANTS_OUT)
                                  : pd_dir_q[4:2];
  // Slave: line 5 is always the select input
  assign pd_dir[`PD_FAULT_LINE]  = pd_dir_q[`PD_FAULT_LINE]
                                 & ~(SPI_ENABLE & ~spi_master);

  assign pd_val[`PD_SCI_RX_LINE] = pd_lat_q[`PD_SCI_RX_LINE];
  assign pd_val[`PD_SCI_TX_LINE] = SCI_TX_EN ? SCI_TXD : pd_lat_q[`PD_SCI_TX_LINE];
  assign pd_val[4:2] = SPI_ENABLE ? SPI_DOUT : pd_lat_q[4:2];
  assign pd_val[7:5] = pd_lat_q[7:5];

  byte_t pd_oe8;

  // Option honoured in every mode
  assign pd_oe8       = drive_en({2'b00, pd_dir}, pd_val, PORT_D_OPEN_DRAIN);
  assign PD_OE        = pd_oe8[5:0];
  assign PD_OUT       = pd_val[5:0];
  assign SPI_DIN      = pd_s[4:2];
  assign SPI_LINE5_IN = pd_s[`PD_FAULT_LINE];
  assign SCI_RXD      = pd_s[`PD_SCI_RX_LINE];

  // --------------------------------------------------------------------
  // Port F: GPIO outputs or low address
  // --------------------------------------------------------------------
  assign PF_OUT = MODE_EXPANDED ? EXT_ADDR_LO : pf_lat_q;

  // --------------------------------------------------------------------
  // Port G: GPIO with chip selects on lines 7..4
  // --------------------------------------------------------------------
  logic [3:0] cs_act;
  byte_t      pg_dir;
  byte_t      pg_val;

  // Program select owns line 7 from reset in expanded modes
  assign cs_act = CS_ENABLE | ({3'b000, MODE_EXPANDED} << `PG_PROG_CS_LINE);
  assign pg_dir = pg_dir_q | {cs_act, 4'h0};
  assign pg_val = {cs_act & CS_LEVEL | ~cs_act & pg_lat_q[7:4], pg_lat_q[3:0]};
  assign PG_OUT = pg_val;
  assign PG_OE  = drive_en(pg_dir, pg_val, g_od);

  // --------------------------------------------------------------------
  // Read-back
  // --------------------------------------------------------------------
  // Port E reads sampled pins through the two-flop synchroniser
  assign rb.rdata = ({8{hit_cd}} & port_view(pc_lat_q, pc_s, pc_dir_q))
                  | ({8{hit_cr}} & pc_dir_q)
                  | ({8{hit_dd}} & port_view(pd_val, pd_s, {2'b00, pd_dir}))
                  | ({8{hit_dr}} & pd_dir_q)
                  | ({8{hit_e}}  & pe_s)
                  | ({8{hit_fd}} & pf_lat_q)
                  | ({8{hit_gd}} & port_view(pg_val, pg_s, pg_dir))
                  | ({8{hit_gr}} & pg_dir_q)
                  | ({8{hit_o}}  & sysopt_q);

  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  property p_pc_input_quiet;
    @(posedge CLK) disable iff (!RESETN)
    !MODE_EXPANDED |-> (PC_OE & ~pc_dir_q) == 8'h00;
  endproperty
  a_pc_input_quiet: assert property (p_pc_input_quiet)
    else $error("port C drives a line set as input");

  property p_dir_reset;
    @(posedge CLK) disable iff (!RESETN)
    $rose(RESETN) |-> (pd_dir_q == 8'h00) && (pg_dir_q == 8'h00) && (PD_OE == 6'h00);
  endproperty
  a_dir_reset: assert property (p_dir_reset)
    else $error("direction not cleared by reset");

  property p_pd_open_drain;
    @(posedge CLK) disable iff (!RESETN)
    PORT_D_OPEN_DRAIN |-> (PD_OE & PD_OUT) == 6'h00;
  endproperty
  a_pd_open_drain: assert property (p_pd_open_drain)
    else $error("port D drives high in open drain");

  property p_pd_dir_upper;
    @(posedge CLK) disable iff (!RESETN)
    (rb.wr_stb && hit_dr) |=> pd_dir_q == ($past(rb.wdata) & 8'h3F);
  endproperty
  a_pd_dir_upper: assert property (p_pd_dir_upper)
    else $error("port D direction write wrong");

  property p_line5_slave;
    @(posedge CLK) disable iff (!RESETN)
    (SPI_ENABLE && SPI_ROLE == SPI_ROLE_SLAVE) |-> !PD_OE[5];
  endproperty
  a_line5_slave: assert property (p_line5_slave)
    else $error("line 5 driven in slave mode");

  property p_spi_lines;
    @(posedge CLK) disable iff (!RESETN)
    SPI_ENABLE |-> (PD_OE[4:2] & ~(SPI_WANTS_OUT & pd_dir_q[4:2])) == 3'h0;
  endproperty
  a_spi_lines: assert property (p_spi_lines)
    else $error("SPI line driven without both enables");

  property p_pf_expanded;
    @(posedge CLK) disable iff (!RESETN)
    (MODE_EXPANDED && PREADY && PWRITE && rb.idx == `IDX_PORT_F_DATA)
      |=> $stable(pf_lat_q) && PF_OUT == EXT_ADDR_LO;
  endproperty
  a_pf_expanded: assert property (p_pf_expanded)
    else $error("port F latch written in expanded mode");

  property p_pg7_prog;
    @(posedge CLK) disable iff (!RESETN)
    MODE_EXPANDED |-> PG_OE[7] || (g_od && PG_OUT[7]);
  endproperty
  a_pg7_prog: assert property (p_pg7_prog)
    else $error("line 7 not program select in expanded mode");

  property p_pg_open_drain;
    @(posedge CLK) disable iff (!RESETN)
    g_od |-> (PG_OE & PG_OUT) == 8'h00;
  endproperty
  a_pg_open_drain: assert property (p_pg_open_drain)
    else $error("port G drives high in open drain");

  property p_pg_gpio_dir;
    @(posedge CLK) disable iff (!RESETN)
    (!MODE_EXPANDED && CS_ENABLE == 4'h0 && !g_od)
      |-> PG_OE == pg_dir_q && PG_OUT == pg_lat_q;
  endproperty
  a_pg_gpio_dir: assert property (p_pg_gpio_dir)
    else $error("port G line not following its direction bit");

  property p_sci_tx_line;
    @(posedge CLK) disable iff (!RESETN)
    SCI_TX_EN |-> PD_OUT[1] == SCI_TXD && (PD_OE[1] || (PORT_D_OPEN_DRAIN && SCI_TXD));
  endproperty
  a_sci_tx_line: assert property (p_sci_tx_line)
    else $error("line 1 not carrying serial transmit");

  property p_sysopt_write;
    @(posedge CLK) disable iff (!RESETN)
    (rb.wr_stb && hit_o) |=> sysopt_q[4:0] == 5'h00
      && sysopt_q[7:5] == $past(rb.wdata[7:5]);
  endproperty
  a_sysopt_write: assert property (p_sysopt_write)
    else $error("options register write wrong");

  property p_pc_bus;
    @(posedge CLK) disable iff (!RESETN)
    MODE_EXPANDED |-> PC_OE == {8{EXT_BUS_WRITE}} && PC_OUT == EXT_DATA_OUT;
  endproperty
  a_pc_bus: assert property (p_pc_bus)
    else $error("port C not following data bus");

endmodule // pio_ports_cg

// ==== pio_cg_params.svh ====
// Constants for the port C..G parallel I/O block: register indices,
// reset values and field positions. Definitions only; no logic.
`ifndef PIO_CG_PARAMS_SVH
`define PIO_CG_PARAMS_SVH

// ----------------------------------------------------------------------
// Register indices (byte address on the bus is four times the index)
// ----------------------------------------------------------------------
`define IDX_PORT_G_DATA   14'h1002
`define IDX_PORT_G_DIR    14'h1003
`define IDX_PORT_F_DATA   14'h1005
`define IDX_PORT_C_DATA   14'h1006
`define IDX_PORT_C_DIR    14'h1007
`define IDX_PORT_D_DATA   14'h1008
`define IDX_PORT_D_DIR    14'h1009
`define IDX_PORT_E_IN     14'h100A
`define IDX_SYSOPT        14'h1038

// ----------------------------------------------------------------------
// Reset values and field layout
// ----------------------------------------------------------------------
`define RST_DIR           8'h00
`define RST_DATA          8'h00
`define RST_SYSOPT        8'h20
`define SYSOPT_G_OD_BIT   7
`define SYSOPT_C_OD_BIT   6
`define SYSOPT_QCLK_BIT   5
`define SYSOPT_IMPL_MASK  8'hE0
`define PD_IMPL_MASK      8'h3F
`define PD_SCI_RX_LINE    0
`define PD_SCI_TX_LINE    1
`define PD_FAULT_LINE     5
`define PG_PROG_CS_LINE   3

`endif

// ==== pio_cg_pkg.sv ====
// Types and helper functions shared by the port C..G I/O block.
// Assumes nothing beyond a SystemVerilog compiler.
package pio_cg_pkg;

  typedef logic [7:0]  byte_t;
  typedef logic [13:0] reg_idx_t;
  typedef enum logic {SPI_ROLE_SLAVE, SPI_ROLE_MASTER} spi_role_e;

  // Data read-back: pin level for inputs, latch for outputs
  function automatic byte_t port_view(byte_t latch, byte_t pin, byte_t dir);
    return (latch & dir) | (pin & ~dir);
  endfunction

  // Open drain: a one leaves the pin undriven
  function automatic byte_t drive_en(byte_t dir, byte_t val, logic od);
    return dir & ~({8{od}} & val);
  endfunction

endpackage

// ==== pio_regbus_if.sv ====
// Internal register strobe bundle between the bus slave and the ports.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps
interface pio_regbus_if;
  import pio_cg_pkg::*;
  logic     wr_stb;
  reg_idx_t idx;
  byte_t    wdata;
  byte_t    rdata;
  logic     miss;
  modport slave (output wr_stb, idx, wdata, input rdata, miss);
  modport regs  (input wr_stb, idx, wdata, output rdata, miss);
endinterface

// ==== pio_apb_slave.sv ====
// APB slave: zero-wait access phase, read data captured at setup.
// Assumes the register side decodes idx combinationally.
`timescale 1ns/10ps
module pio_apb_slave (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        ce,
  // APB
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [15:0] paddr,
  input  wire logic [31:0] pwdata,
  output      logic        pready,
  output      logic [31:0] prdata,
  output      logic        pslverr,
  // Register side
  pio_regbus_if.slave      bus
);
  import pio_cg_pkg::*;

  logic        setup;
  logic        err_d;
  logic        err_q;
  logic [31:0] rdata_q;

  assign setup      = psel & ~penable;
  assign err_d      = (paddr[1:0] != 2'h0) | bus.miss;
  assign bus.idx    = paddr[15:2];
  assign bus.wdata  = pwdata[7:0];
  // Frozen clock enable stretches the access phase
  assign pready     = psel & penable & ce;
  assign bus.wr_stb = pready & pwrite & ~err_q;
  assign prdata     = rdata_q;
  assign pslverr    = pready & err_q;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdata_q <= 32'h0000_0000;
      err_q   <= 1'b0;
    end else if (ce && setup) begin
      rdata_q <= {24'h00_0000, bus.rdata};
      err_q   <= err_d;
    end
  end

endmodule // pio_apb_slave

// ==== pio_sync.sv ====
// Two-flop synchroniser for pin inputs.
// Assumes inputs are quasi-static relative to CLK.
`timescale 1ns/10ps
module pio_sync #(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic         resetn,
  input  wire logic         ce,
  input  wire logic [W-1:0] d,
  output      logic [W-1:0] q
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      meta_q <= '0;
      q      <= '0;
    end else if (ce) begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule // pio_sync

// ==== pio_pins_model.sv ====
// Board around ports C, D and G: pull-ups on every line, plus external
// drivers that the bench switches on and off. Assumes OE/OUT are combinational.
`timescale 1ns/10ps
module pio_pins_model (
  // Design side
  input  wire logic [7:0]  pc_out,
  input  wire logic [7:0]  pc_oe,
  input  wire logic [5:0]  pd_out,
  input  wire logic [5:0]  pd_oe,
  input  wire logic [7:0]  pg_out,
  input  wire logic [7:0]  pg_oe,
  // External drivers: C in 7:0, D in 13:8, G in 23:16
  input  wire logic [23:0] ext_val,
  input  wire logic [23:0] ext_en,
  // Resolved pin levels
  output      logic [7:0]  pc_in,
  output      logic [5:0]  pd_in,
  output      logic [7:0]  pg_in
);
  logic [7:0] d_full;

  // ----------------------------------------------------------------------
  // Wire resolution
  // ----------------------------------------------------------------------
  // Undriven line falls back to the pull-up, never to the last value
  function automatic logic [7:0] res(logic [7:0] o, logic [7:0] oe, logic [7:0] v,
                                     logic [7:0] e);
    return (o & oe) | (~oe & ((v & e) | ~e));
  endfunction

  assign pc_in  = res(pc_out, pc_oe, ext_val[7:0], ext_en[7:0]);
  assign d_full = res({2'h0, pd_out}, {2'h0, pd_oe}, ext_val[15:8], ext_en[15:8]);
  assign pd_in  = d_full[5:0];
  assign pg_in  = res(pg_out, pg_oe, ext_val[23:16], ext_en[23:16]);
endmodule // pio_pins_model

// ==== parallel_io_ports_c_to_g_tb.sv ====
// Self-checking bench for the port C..G block: APB master, register model,
// board model on the pins. Assumes a single 100 MHz clock.
`timescale 1ns/10ps
`include "pio_cg_params.svh"
module parallel_io_ports_c_to_g_tb;
  import pio_cg_pkg::*;
  logic              CLK = 1'b0, RESETN = 1'b0, CE = 1'b1;
  logic              PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
  logic [15:0]       PADDR = 16'h0;
  logic [31:0]       PWDATA = 32'h0, PRDATA;
  logic              PREADY, PSLVERR, MODE_EXPANDED = 1'b0, SPI_ENABLE = 1'b0;
  spi_role_e         SPI_ROLE = SPI_ROLE_SLAVE;
  logic [2:0]        SPI_WANTS_OUT = 3'h0, SPI_DOUT = 3'h0, SPI_DIN;
  logic              PORT_D_OPEN_DRAIN = 1'b0, SCI_TX_EN = 1'b0, SCI_TXD = 1'b0;
  logic              SCI_RX_EN = 1'b0, SPI_LINE5_IN, SCI_RXD, EXT_BUS_WRITE = 1'b0;
  logic [7:0]        EXT_DATA_OUT = 8'h0, EXT_ADDR_LO = 8'h0, EXT_DATA_IN, PE_IN = 8'h0;
  logic [3:0]        CS_ENABLE = 4'h0, CS_LEVEL = 4'h0;
  logic              QUAD_CLOCK_OUT_EN;
  logic [7:0]        PC_IN, PC_OUT, PC_OE, PF_OUT, PG_IN, PG_OUT, PG_OE, dd, cs, pv;
  logic [5:0]        PD_IN, PD_OUT, PD_OE;
  logic [23:0]       ev = 24'h0, en = 24'h0;
  logic [31:0]       xr;
  logic              xe;
  logic [7:0]        m [int];
  int                n_fail = 0, compares = 0;
  int                regs [9] = '{`IDX_PORT_G_DATA, `IDX_PORT_G_DIR, `IDX_PORT_F_DATA,
                                  `IDX_PORT_C_DATA, `IDX_PORT_C_DIR, `IDX_PORT_D_DATA,
                                  `IDX_PORT_D_DIR, `IDX_PORT_E_IN, `IDX_SYSOPT};

  always #5 CLK = ~CLK;

  pio_ports_cg dut (.CLK, .RESETN, .CE, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PREADY,
    .PRDATA, .PSLVERR, .MODE_EXPANDED, .SPI_ENABLE, .SPI_ROLE, .SPI_WANTS_OUT, .SPI_DOUT,
    .PORT_D_OPEN_DRAIN, .SCI_TX_EN, .SCI_TXD, .SCI_RX_EN, .SPI_DIN, .SPI_LINE5_IN, .SCI_RXD,
    .EXT_BUS_WRITE, .EXT_DATA_OUT, .EXT_ADDR_LO, .CS_ENABLE, .CS_LEVEL, .EXT_DATA_IN,
    .QUAD_CLOCK_OUT_EN, .PC_IN, .PC_OUT, .PC_OE, .PD_IN, .PD_OUT, .PD_OE, .PE_IN, .PF_OUT,
    .PG_IN, .PG_OUT, .PG_OE);

  pio_pins_model pins (.pc_out(PC_OUT), .pc_oe(PC_OE), .pd_out(PD_OUT), .pd_oe(PD_OE),
    .pg_out(PG_OUT), .pg_oe(PG_OE), .ext_val(ev), .ext_en(en), .pc_in(PC_IN),
    .pd_in(PD_IN), .pg_in(PG_IN));

  // ----------------------------------------------------------------------
  // Model, bus and compare tasks
  // ----------------------------------------------------------------------
  function automatic logic [7:0] pinv(logic [7:0] v, logic [7:0] e);
    return (v & e) | ~e;
  endfunction

  function automatic logic [7:0] wmask(int i);
    if (i == `IDX_PORT_D_DIR || i == `IDX_PORT_D_DATA)
      return 8'h3F;
    return (i == `IDX_SYSOPT) ? 8'hE0 : 8'hFF;
  endfunction

  function automatic logic [31:0] exp_rd(int i);
    logic [7:0] p;
    case (i)
      `IDX_PORT_G_DATA: p = pinv(ev[23:16], en[23:16]);
      `IDX_PORT_C_DATA: p = pinv(ev[7:0], en[7:0]);
      `IDX_PORT_D_DATA: p = pinv(ev[15:8], en[15:8]) & 8'h3F;
      `IDX_PORT_E_IN:   return {24'h0, PE_IN};
      default:          return {24'h0, m[i]};
    endcase
    return {24'h0, (m[i] & m[i + 1]) | (p & ~m[i + 1])};
  endfunction

  task automatic stop_test;
    $display("compares %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(logic [31:0] got, logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_reg(logic [31:0] got, logic [31:0] exp);
    chk(got, exp);
  endtask

  task automatic cmp_pin(logic [7:0] got, logic [7:0] exp);
    chk({24'h0, got}, {24'h0, exp});
  endtask

  // Holds the request until PREADY is seen high at a rising edge, or gives up and fails after 50 edges
  task automatic apb(logic wr, int i, logic [7:0] wd, output logic [31:0] rd,
                     output logic er);
    int k;
    @(posedge CLK);
    PSEL    <= 1'b1;
    PWRITE  <= wr;
    PADDR   <= 16'(i * 4);
    PWDATA  <= {24'h0, wd};
    @(posedge CLK);
    PENABLE <= 1'b1;
    k = 0;
    do begin
      @(posedge CLK);
      k++;
    end while (PREADY !== 1'b1 && k < 50);
    rd = PRDATA;
    er = PSLVERR;
    PSEL    <= 1'b0;
    PENABLE <= 1'b0;
    if (k >= 50)
      chk(32'h0, 32'h1);
  endtask

  task automatic wr(int i, logic [7:0] v);
    logic [31:0] rd;
    logic        er;
    apb(1'b1, i, v, rd, er);
    if (i != `IDX_PORT_E_IN)
      m[i] = v & wmask(i);
  endtask

  task automatic rd_chk(int i, logic e);
    logic [31:0] rd;
    logic        er;
    apb(1'b0, i, 8'h0, rd, er);
    cmp_reg({31'h0, er}, {31'h0, e});
    cmp_reg(rd, e ? 32'h0 : exp_rd(i));
  endtask

  // Single-chip pin view with no alternate function active
  task automatic pins_sc;
    logic [7:0] gd, cd, pd;
    gd = m[`IDX_PORT_G_DIR] & ~({8{m[`IDX_SYSOPT][7]}} & m[`IDX_PORT_G_DATA]);
    cd = m[`IDX_PORT_C_DIR] & ~({8{m[`IDX_SYSOPT][6]}} & m[`IDX_PORT_C_DATA]);
    pd = m[`IDX_PORT_D_DIR] & ~({8{PORT_D_OPEN_DRAIN}} & m[`IDX_PORT_D_DATA]);
    cmp_pin(PG_OE, gd);
    cmp_pin(PC_OE, cd);
    cmp_pin({2'h0, PD_OE}, pd);
    cmp_pin(PG_OUT & gd, m[`IDX_PORT_G_DATA] & gd);
    cmp_pin(PC_OUT & cd, m[`IDX_PORT_C_DATA] & cd);
    cmp_pin({2'h0, PD_OUT} & pd, m[`IDX_PORT_D_DATA] & pd);
    cmp_pin(PF_OUT, m[`IDX_PORT_F_DATA]);
    cmp_pin({7'h0, QUAD_CLOCK_OUT_EN}, {7'h0, m[`IDX_SYSOPT][5]});
  endtask

  initial begin
    #200000;
    n_fail++;
    stop_test;
  end

  // ----------------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------------
  initial begin
    void'($urandom(32'hABB8908C));
    foreach (regs[j]) m[regs[j]] = 8'h00;
    m[`IDX_SYSOPT] = 8'h20;
    repeat (3) @(posedge CLK);
    RESETN <= 1'b1;
    // Pin synchronisers need two edges before reads see the pins
    repeat (2) @(posedge CLK);
    foreach (regs[j]) rd_chk(regs[j], 1'b0);
    pins_sc;
    $display("test reset done");
    repeat (8) begin
      ev <= 24'($urandom);
      en <= 24'($urandom);
      PE_IN <= 8'($urandom);
      PORT_D_OPEN_DRAIN <= 1'($urandom);
      foreach (regs[j]) wr(regs[j], 8'($urandom));
      repeat (3) @(posedge CLK);
      foreach (regs[j]) rd_chk(regs[j], 1'b0);
      pins_sc;
    end
    rd_chk(14'h1000, 1'b1);
    $display("test registers and pins done");
    wr(`IDX_SYSOPT, 8'h40);
    MODE_EXPANDED <= 1'b1;
    repeat (4) begin
      EXT_ADDR_LO <= 8'($urandom);
      EXT_DATA_OUT <= 8'($urandom);
      EXT_BUS_WRITE <= 1'($urandom);
      CS_ENABLE <= 4'($urandom);
      CS_LEVEL <= 4'($urandom);
      repeat (3) @(posedge CLK);
      cs = {1'b1, CS_ENABLE[2:0], 4'h0};
      cmp_pin(PF_OUT, EXT_ADDR_LO);
      cmp_pin(PC_OE, {8{EXT_BUS_WRITE}});
      cmp_pin(PC_OUT & PC_OE, EXT_DATA_OUT & PC_OE);
      cmp_pin(PG_OE & 8'hF0, (cs | m[`IDX_PORT_G_DIR]) & 8'hF0);
      cmp_pin(PG_OUT & cs, {CS_LEVEL, 4'h0} & cs);
      if (!EXT_BUS_WRITE)
        cmp_pin(EXT_DATA_IN, pinv(ev[7:0], en[7:0]));
      apb(1'b1, `IDX_PORT_F_DATA, 8'($urandom), xr, xe);
      cmp_reg({31'h0, xe}, 32'h1);
      rd_chk(`IDX_PORT_C_DATA, 1'b1);
      rd_chk(`IDX_PORT_F_DATA, 1'b1);
    end
    $display("test expanded mode done");
    MODE_EXPANDED <= 1'b0;
    PORT_D_OPEN_DRAIN <= 1'b0;
    SPI_ENABLE <= 1'b1;
    rd_chk(`IDX_PORT_F_DATA, 1'b0);
    repeat (10) begin
      SPI_ROLE <= spi_role_e'($urandom_range(1));
      SPI_WANTS_OUT <= 3'($urandom);
      SPI_DOUT <= 3'($urandom);
      SCI_TX_EN <= 1'($urandom);
      SCI_TXD <= 1'($urandom);
      SCI_RX_EN <= 1'($urandom);
      wr(`IDX_PORT_D_DIR, 8'($urandom));
      repeat (3) @(posedge CLK);
      dd = m[`IDX_PORT_D_DIR];
      dd[5] = dd[5] & (SPI_ROLE == SPI_ROLE_MASTER);
      dd[4:2] = dd[4:2] & SPI_WANTS_OUT;
      dd[1] = dd[1] | SCI_TX_EN;
      dd[0] = dd[0] & !SCI_RX_EN;
      cmp_pin({2'h0, PD_OE}, dd);
      cmp_pin({5'h0, PD_OUT[4:2] & dd[4:2]}, {5'h0, SPI_DOUT & dd[4:2]});
      if (SCI_TX_EN)
        cmp_pin({7'h0, PD_OUT[1]}, {7'h0, SCI_TXD});
      pv = m[`IDX_PORT_D_DATA];
      pv[4:2] = SPI_DOUT;
      if (SCI_TX_EN)
        pv[1] = SCI_TXD;
      pv = ((pv & dd) | (pinv(ev[15:8], en[15:8]) & ~dd)) & 8'h3F;
      cmp_pin({5'h0, SPI_DIN}, {5'h0, pv[4:2]});
      cmp_pin({6'h0, SPI_LINE5_IN, SCI_RXD}, {6'h0, pv[5], pv[0]});
    end
    $display("test serial sharing done");
    // Frozen enable must hold the synchronised pins
    CE <= 1'b0;
    en <= 24'h0;
    repeat (4) @(posedge CLK);
    cmp_pin({5'h0, SPI_DIN}, {5'h0, pv[4:2]});
    CE <= 1'b1;
    $display("test clock enable done");
    stop_test;
  end
endmodule // parallel_io_ports_c_to_g_tb
